/* design/dual_port_serial_arbiter.sv */
// Dual port arbiter with three-wire shifter, single-wire front end and rx FIFO
// Function
// - Select rising starts a three-wire transfer
// - Select low ends transaction immediately
// - Clock cycle is falling then rising edge
// - Input bits sampled on rising clock edge
// - Read bits driven from falling clock edge
// - Data driver released while clock high
// - Select low aborts, data line tristated
// - No communication while on backup battery
// - Block ports during supply settling delay
// - First active port wins the grant
// - Three-wire active on select rising
// - Single-wire active on first fall after presence
// - Denied port never disturbs granted port
// - Denied single-wire still answers reset
// - Denied single-wire reads return all ones
// - Single-wire grant keeps data line tristated
// - Presence pulse follows reset after delay
`timescale 1ns/1ps

// ****************************************
// Receive FIFO
// ****************************************
module rx_fifo #(
    parameter int W = 8,
    parameter int D = 4
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [W-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [W-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = (D > 1) ? $clog2(D) : 1;
    logic [W-1:0] mem [D];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    logic push;
    logic pop;

    if (D < 2 || (1 << AW) != D) begin : g_bad_depth
        $error("rx_fifo depth must be a power of two, at least 2");
    end

    assign in_ready = cnt_q != (AW+1)'(D);
    assign out_valid = cnt_q != '0;
    assign out_data = mem[rd_q];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem[wr_q] <= in_data;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
            cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        end
    end
endmodule : rx_fifo

// ****************************************
// Arbiter top
// ****************************************
module dual_port_serial_arbiter import arb_pkg::*; #(
    parameter int RST_LOW_CYCLES = RST_LOW_CYC,
    parameter int SETTLE_CYCLES = SETTLE_CYC
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic sel_pin,
    input wire logic sclk_pin,
    input wire logic dq_in,
    output logic dq_out,
    output logic dq_oe_n,
    input wire logic ow_in,
    output logic ow_out,
    output logic ow_oe_n,
    input wire logic supply_ok,
    input wire logic osc_on,
    input wire logic rd_mode,
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    output logic tx_ready,
    output logic [7:0] rx_data,
    output logic rx_valid,
    input wire logic rx_ready,
    output logic rx_overrun,
    output logic ow_slot,
    input wire logic ow_send_zero,
    output logic grant_tw,
    output logic grant_ow,
    output logic comm_en
);
    if (RST_LOW_CYCLES < 1 || RST_LOW_CYCLES >= (1 << OW_CNT_W)
        || SETTLE_CYCLES < 1 || SETTLE_CYCLES >= (1 << SETTLE_W)) begin : g_bad
        $error("timing parameters out of counter range");
    end

    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic [1:0] sel_sy, sclk_sy, dq_sy, ow_sy, sup_sy, osc_sy;
    logic sel_d, sclk_d, ow_d, sup_d;
    logic sel_s, sclk_s, dq_s, ow_s, sup_s, osc_s;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            sel_sy <= '0;
            sclk_sy <= '0;
            dq_sy <= '0;
            ow_sy <= 2'h3;
            sup_sy <= '0;
            osc_sy <= '0;
            sel_d <= 1'b0;
            sclk_d <= 1'b0;
            ow_d <= 1'b1;
            sup_d <= 1'b0;
        end else begin
            sel_sy <= {sel_sy[0], sel_pin};
            sclk_sy <= {sclk_sy[0], sclk_pin};
            dq_sy <= {dq_sy[0], dq_in};
            ow_sy <= {ow_sy[0], ow_in};
            sup_sy <= {sup_sy[0], supply_ok};
            osc_sy <= {osc_sy[0], osc_on};
            sel_d <= sel_s;
            sclk_d <= sclk_s;
            ow_d <= ow_s;
            sup_d <= sup_s;
        end
    end

    assign sel_s = sel_sy[1];
    assign sclk_s = sclk_sy[1];
    assign dq_s = dq_sy[1];
    assign ow_s = ow_sy[1];
    assign sup_s = sup_sy[1];
    assign osc_s = osc_sy[1];

    logic sel_rise, sclk_rise, sclk_fall, ow_rise, ow_fall;
    assign sel_rise = sel_s && !sel_d;
    assign sclk_rise = sclk_s && !sclk_d;
    assign sclk_fall = !sclk_s && sclk_d;
    assign ow_rise = ow_s && !ow_d;
    assign ow_fall = !ow_s && ow_d;

    // ****************************************
    // Power gating
    // ****************************************
    // Delay only applies with the oscillator running; without it access opens at once
    logic [SETTLE_W-1:0] settle_q;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            settle_q <= '0;
            comm_en <= 1'b0;
        end else if (!sup_s) begin
            settle_q <= '0;
            comm_en <= 1'b0;
        end else if (!osc_s) begin
            comm_en <= 1'b1;
        end else if (!comm_en) begin
            settle_q <= settle_q + 1'b1;
            comm_en <= settle_q == SETTLE_W'(SETTLE_CYCLES - 1);
        end
    end

    // ****************************************
    // Single-wire front end
    // ****************************************
    ow_state_t ow_st;
    logic [OW_CNT_W-1:0] ow_low_q, ow_tmr_q;
    logic ow_zero_q, ow_reset_seen, ow_req;
    grant_t grant_q;

    assign ow_reset_seen = ow_rise && ow_low_q >= OW_CNT_W'(RST_LOW_CYCLES);
    assign ow_req = ow_st == OW_LIVE && ow_fall;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ow_low_q <= '0;
        end else if (ow_s || !ow_oe_n) begin
            // Own presence or zero pulls must never look like a master reset
            ow_low_q <= '0;
        end else if (ow_low_q != '1) begin
            ow_low_q <= ow_low_q + 1'b1;
        end
    end

    // Presence answers regardless of grant, but not while access is blocked
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ow_st <= OW_IDLE;
            ow_tmr_q <= '0;
        end else if (!comm_en) begin
            ow_st <= OW_IDLE;
            ow_tmr_q <= '0;
        end else if (ow_reset_seen) begin
            ow_st <= OW_WAIT;
            ow_tmr_q <= '0;
        end else begin
            case (ow_st)
                OW_WAIT: begin
                    ow_tmr_q <= ow_tmr_q + 1'b1;
                    if (ow_tmr_q == OW_CNT_W'(PDH_CYC - 1)) begin
                        ow_st <= OW_PRES;
                        ow_tmr_q <= '0;
                    end
                end
                OW_PRES: begin
                    ow_tmr_q <= ow_tmr_q + 1'b1;
                    if (ow_tmr_q == OW_CNT_W'(PDL_CYC - 1)) begin
                        ow_st <= OW_LIVE;
                        ow_tmr_q <= '0;
                    end
                end
                OW_IDLE, OW_LIVE: ow_tmr_q <= '0;
                default: ow_st <= OW_IDLE;
            endcase
        end
    end

    // Denied slots never pull low, so the master reads ones
    logic [OW_CNT_W-1:0] zero_q;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ow_zero_q <= 1'b0;
            zero_q <= '0;
            ow_slot <= 1'b0;
        end else begin
            ow_slot <= ow_fall && ow_st == OW_LIVE && grant_q == G_OW && comm_en;
            if (ow_slot && ow_send_zero) begin
                ow_zero_q <= 1'b1;
                zero_q <= '0;
            end else if (ow_zero_q) begin
                zero_q <= zero_q + 1'b1;
                ow_zero_q <= zero_q != OW_CNT_W'(ZERO_HOLD_CYC - 1);
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ow_oe_n <= 1'b1;
        end else begin
            ow_oe_n <= !(ow_st == OW_PRES || (ow_zero_q && grant_q == G_OW));
        end
    end
    assign ow_out = 1'b0;

    // ****************************************
    // Arbiter
    // ****************************************
    // A same-cycle tie goes to the three-wire port
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            grant_q <= G_IDLE;
        end else if (!comm_en || !sup_s) begin
            grant_q <= G_IDLE;
        end else begin
            case (grant_q)
                G_IDLE: begin
                    if (sel_rise) begin
                        grant_q <= G_TW;
                    end else if (ow_req) begin
                        grant_q <= G_OW;
                    end
                end
                G_TW: if (!sel_s) grant_q <= G_IDLE;
                G_OW: if (ow_reset_seen) grant_q <= G_IDLE;
                default: grant_q <= G_IDLE;
            endcase
        end
    end
    assign grant_tw = grant_q == G_TW;
    assign grant_ow = grant_q == G_OW;

    // ****************************************
    // Three-wire shifter
    // ****************************************
    logic tw_act;
    logic [2:0] bit_q;
    logic [7:0] sh_q, rx_hold_q;
    logic rx_pend_q, fifo_in_ready;
    assign tw_act = grant_q == G_TW && sel_s;
    assign tx_ready = tw_act && rd_mode && sclk_fall && bit_q == '0;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            bit_q <= '0;
            sh_q <= '0;
            dq_out <= 1'b0;
        end else if (!tw_act || sel_rise) begin
            bit_q <= '0;
        end else if (sclk_rise && !rd_mode) begin
            sh_q <= {dq_s, sh_q[7:1]};
            bit_q <= bit_q + 1'b1;
        end else if (sclk_fall && rd_mode) begin
            if (bit_q == '0) begin
                dq_out <= tx_valid ? tx_data[0] : IDLE_BYTE[0];
                sh_q <= tx_valid ? {1'b1, tx_data[7:1]} : IDLE_BYTE;
            end else begin
                dq_out <= sh_q[0];
                sh_q <= {1'b1, sh_q[7:1]};
            end
            bit_q <= bit_q + 1'b1;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            dq_oe_n <= 1'b1;
        end else if (!tw_act || sclk_s) begin
            dq_oe_n <= 1'b1;
        end else if (sclk_fall && rd_mode) begin
            dq_oe_n <= 1'b0;
        end
    end

    // Host cannot be stalled: a byte finishing while one still waits replaces it, and the waiting byte is lost
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rx_pend_q <= 1'b0;
            rx_hold_q <= '0;
            rx_overrun <= 1'b0;
        end else begin
            if (rx_pend_q && fifo_in_ready) begin
                rx_pend_q <= 1'b0;
            end
            if (tw_act && sclk_rise && !rd_mode && bit_q == 3'h7) begin
                rx_hold_q <= {dq_s, sh_q[7:1]};
                rx_pend_q <= 1'b1;
                if (rx_pend_q && !fifo_in_ready) begin
                    rx_overrun <= 1'b1;
                end
            end else if (sel_rise) begin
                rx_overrun <= 1'b0;
            end
        end
    end

    rx_fifo #(.W(BYTE_BITS), .D(FIFO_DEPTH)) u_fifo (
        .sys_clk(sys_clk),
        .rst(rst),
        .in_data(rx_hold_q),
        .in_valid(rx_pend_q),
        .in_ready(fifo_in_ready),
        .out_data(rx_data),
        .out_valid(rx_valid),
        .out_ready(rx_ready)
    );

    // ****************************************
    // Checks
    // ****************************************
    a_clk_high_release: assert property (@(posedge sys_clk) disable iff (rst)
        sclk_s && sclk_d |-> dq_oe_n) else $error("dq driven while clock high");
    a_sel_low_tristate: assert property (@(posedge sys_clk) disable iff (rst)
        !sel_s |=> dq_oe_n) else $error("dq driven with select low");
    a_ow_grant_dq_off: assert property (@(posedge sys_clk) disable iff (rst)
        grant_q == G_OW |-> dq_oe_n) else $error("dq driven under single-wire grant");
    a_blocked_no_grant: assert property (@(posedge sys_clk) disable iff (rst)
        !sup_s |=> grant_q == G_IDLE && !comm_en) else $error("grant while on battery");
    a_settle_holds: assert property (@(posedge sys_clk) disable iff (rst)
        sup_s && !sup_d && osc_s |=> !comm_en [*8]) else $error("access before settling");
    a_tw_first_grant: assert property (@(posedge sys_clk) disable iff (rst)
        grant_q == G_IDLE && comm_en && sel_rise |=> grant_q == G_TW)
        else $error("three-wire not granted");
    a_ow_first_grant: assert property (@(posedge sys_clk) disable iff (rst)
        grant_q == G_IDLE && comm_en && ow_req && !sel_rise |=> grant_q == G_OW)
        else $error("single-wire not granted");
    a_tw_grant_kept: assert property (@(posedge sys_clk) disable iff (rst)
        grant_q == G_TW && sel_s && comm_en && sup_s |=> grant_q == G_TW)
        else $error("three-wire grant lost");
    a_denied_ones: assert property (@(posedge sys_clk) disable iff (rst)
        !ow_oe_n |-> $past(ow_st) == OW_PRES || $past(grant_q) == G_OW)
        else $error("denied single-wire pulled low");
    a_rx_sample_rise: assert property (@(posedge sys_clk) disable iff (rst)
        tw_act && sclk_rise && !rd_mode |=> sh_q[7] == $past(dq_s))
        else $error("bit not sampled on rising edge");
    a_rd_drive_fall: assert property (@(posedge sys_clk) disable iff (rst)
        tw_act && sclk_fall && rd_mode |=> !dq_oe_n) else $error("read bit not driven");
endmodule : dual_port_serial_arbiter

/* design/arb_pkg.sv */
// Constants and types shared by the dual port serial arbiter
package arb_pkg;
    // ****************************************
    // Clock and timing
    // ****************************************
    localparam int CLK_HZ = 20_000_000;
    localparam int CYC_PER_US = CLK_HZ / 1_000_000;
    localparam int RST_LOW_US = 480;
    localparam int PDH_US = 30;
    localparam int PDL_US = 120;
    localparam int ZERO_HOLD_US = 30;
    localparam int SETTLE_MS = 123;
    localparam int RST_LOW_CYC = RST_LOW_US * CYC_PER_US;
    localparam int PDH_CYC = PDH_US * CYC_PER_US;
    localparam int PDL_CYC = PDL_US * CYC_PER_US;
    localparam int ZERO_HOLD_CYC = ZERO_HOLD_US * CYC_PER_US;
    localparam int SETTLE_CYC = SETTLE_MS * (CLK_HZ / 1000);
    // ****************************************
    // Widths
    // ****************************************
    localparam int BYTE_BITS = 8;
    localparam int FIFO_DEPTH = 4;
    localparam int OW_CNT_W = 16;
    localparam int SETTLE_W = 22;
    localparam logic [7:0] IDLE_BYTE = 8'hFF;
    // ****************************************
    // States
    // ****************************************
    typedef enum logic [1:0] {
        G_IDLE = 2'b00,
        G_TW = 2'b01,
        G_OW = 2'b10
    } grant_t;
    typedef enum logic [1:0] {
        OW_IDLE = 2'b00,
        OW_WAIT = 2'b01,
        OW_PRES = 2'b10,
        OW_LIVE = 2'b11
    } ow_state_t;
endpackage : arb_pkg

/* verification/tw_ow_host.sv */
// Behavioural host microcontroller and single-wire master at the arbiter's pins
`timescale 1ns/1ps
module tw_ow_host #(
    parameter int RST_LOW_CYCLES = 50
) (
    input wire logic sys_clk,
    input wire logic dq_wire,
    output logic sel,
    output logic sclk,
    output logic host_dq,
    output logic host_oe,
    output logic ow_low
);
    initial begin
        sel = 1'b0;
        sclk = 1'b0;
        host_dq = 1'b0;
        host_oe = 1'b0;
        ow_low = 1'b0;
    end
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #2;
    endtask : wait_cyc
    // ****************************************
    // Three-wire port
    // ****************************************
    task automatic tw_open(input logic rd);
        sel = 1'b1;
        wait_cyc(20);
        if (rd) begin
            // Reads need a high clock so the first cycle can open with a fall
            sclk = 1'b1;
            wait_cyc(4);
        end
    endtask : tw_open
    // Low half 250 ns, high half 150 ns; last bit of a byte keeps clock high longer
    task automatic tw_bits(input int n, input logic rd, input logic [7:0] wb,
                           output logic [7:0] rb);
        rb = 8'h00;
        if (host_oe == rd) host_oe = !rd;
        for (int i = 0; i < n; i++) begin
            sclk = 1'b0;
            host_dq = wb[i];
            wait_cyc(5);
            rb[i] = dq_wire;
            sclk = 1'b1;
            wait_cyc(i == 7 ? 8 : 3);
        end
    endtask : tw_bits
    task automatic tw_lowhalf();
        sclk = 1'b0;
        wait_cyc(6);
    endtask : tw_lowhalf
    task automatic tw_close();
        sclk = 1'b0;
        sel = 1'b0;
        host_oe = 1'b0;
        wait_cyc(1);
    endtask : tw_close
    // ****************************************
    // Single-wire master
    // ****************************************
    task automatic ow_reset();
        ow_low = 1'b1;
        wait_cyc(RST_LOW_CYCLES + 10);
        ow_low = 1'b0;
    endtask : ow_reset
    task automatic ow_fall();
        ow_low = 1'b1;
        wait_cyc(20);
        ow_low = 1'b0;
    endtask : ow_fall
endmodule : tw_ow_host

/* verification/dual_port_serial_arbiter_bench.sv */
// Self-checking bench for the dual port serial arbiter
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_total++; \
    $display("FAIL t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module dual_port_serial_arbiter_bench;
    import arb_pkg::*;
    localparam int RST_SIM = 50;
    localparam int SETTLE_SIM = 20;
    logic sys_clk, rst, supply_ok, osc_on, rd_mode, tx_valid, rx_ready, ow_send_zero;
    logic [7:0] tx_data, rx_data, wb, rb;
    logic dq_in, dq_out, dq_oe_n, ow_in, ow_out, ow_oe_n, tx_ready, rx_valid, rx_overrun;
    logic ow_slot, grant_tw, grant_ow, comm_en;
    logic sel, sclk, host_dq, host_oe, ow_low;
    logic [31:0] seed = 32'h0000001D;
    int err_total = 0;
    int checks = 0;
    int slot_n = 0;
    int pull_n = 0;
    int drv_n = 0;
    int hi_n = 0;
    int n, s, p, d;
    logic [7:0] exp_q[$];
    // Pulldown on the data line, pull-up on the single-wire line
    assign dq_in = !dq_oe_n ? dq_out : (host_oe ? host_dq : 1'b0);
    assign ow_in = !ow_low && (ow_oe_n || ow_out);
    dual_port_serial_arbiter #(.RST_LOW_CYCLES(RST_SIM), .SETTLE_CYCLES(SETTLE_SIM)) dut (
        .sys_clk(sys_clk), .rst(rst), .sel_pin(sel), .sclk_pin(sclk), .dq_in(dq_in),
        .dq_out(dq_out), .dq_oe_n(dq_oe_n), .ow_in(ow_in), .ow_out(ow_out), .ow_oe_n(ow_oe_n),
        .supply_ok(supply_ok), .osc_on(osc_on), .rd_mode(rd_mode), .tx_data(tx_data),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid),
        .rx_ready(rx_ready), .rx_overrun(rx_overrun), .ow_slot(ow_slot),
        .ow_send_zero(ow_send_zero), .grant_tw(grant_tw), .grant_ow(grant_ow),
        .comm_en(comm_en));
    tw_ow_host #(.RST_LOW_CYCLES(RST_SIM)) host (
        .sys_clk(sys_clk), .dq_wire(dq_in), .sel(sel), .sclk(sclk), .host_dq(host_dq),
        .host_oe(host_oe), .ow_low(ow_low));
    // ****************************************
    // Helpers
    // ****************************************
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    function automatic logic [7:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction : xs
    task automatic step(input int k);
        repeat (k) @(posedge sys_clk);
        #2;
    endtask : step
    task automatic give_verdict();
        $display("checks=%0d err_total=%0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : give_verdict
    task automatic ow_reset_chk();
        host.ow_reset();
        step(570);
        `CHK(ow_oe_n, 1'b1)
        step(50);
        `CHK(ow_oe_n, 1'b0)
        `CHK(ow_in, 1'b0)
        step(2450);
        `CHK(ow_oe_n, 1'b1)
    endtask : ow_reset_chk
    task automatic pop_cmp(input logic [7:0] e);
        n = 0;
        while (rx_valid !== 1'b1 && n < 20) begin step(1); n++; end
        `CHK(rx_data, e)
        rx_ready = 1'b1;
        step(1);
        rx_ready = 1'b0;
        step(1);
    endtask : pop_cmp
    // Event counters; a released clock that stays high must see the driver off
    always @(posedge sys_clk) begin
        if (ow_slot === 1'b1) slot_n++;
        if (ow_oe_n === 1'b0) pull_n++;
        if (dq_oe_n === 1'b0) drv_n++;
        hi_n = (sel && sclk) ? hi_n + 1 : 0;
        if (hi_n == 6) `CHK(dq_oe_n, 1'b1)
        if (tx_ready === 1'b1) tx_valid <= 1'b0;
    end
    initial begin
        #(30000 * 50);
        err_total++;
        give_verdict();
    end
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        rst = 1'b1; supply_ok = 1'b0; osc_on = 1'b1; rd_mode = 1'b0; tx_valid = 1'b0;
        tx_data = 8'h00; rx_ready = 1'b0; ow_send_zero = 1'b0;
        step(16);
        rst = 1'b0;
        `CHK({dq_oe_n, ow_oe_n, comm_en, grant_tw, grant_ow, rx_valid}, 6'h30)
        step(40);
        `CHK(comm_en, 1'b0)
        supply_ok = 1'b1;
        n = 0;
        while (comm_en !== 1'b1 && n < 100) begin step(1); n++; end
        `CHK(n >= SETTLE_SIM, 1'b1)
        `CHK(comm_en, 1'b1)
        ow_reset_chk();
        // Six bytes: four buffered, one held, the held one replaced by the last
        host.tw_open(1'b0);
        `CHK({grant_tw, grant_ow}, 2'h2)
        for (int k = 0; k < FIFO_DEPTH + 2; k++) begin
            wb = (k == FIFO_DEPTH + 1) ? 8'h00 : xs();
            host.tw_bits(8, 1'b0, wb, rb);
            if (k != FIFO_DEPTH) exp_q.push_back(wb);
            if (k == 1) begin
                s = slot_n; p = pull_n; ow_send_zero = 1'b1;
                host.ow_fall();
                step(700);
                `CHK(slot_n, s)
                `CHK(pull_n, p)
                `CHK(grant_ow, 1'b0)
                ow_reset_chk();
                `CHK(grant_tw, 1'b1)
                ow_send_zero = 1'b0;
            end
        end
        `CHK(rx_overrun, 1'b1)
        host.tw_close();
        step(5);
        `CHK(grant_tw, 1'b0)
        while (exp_q.size() > 0) pop_cmp(exp_q.pop_front());
        step(3);
        `CHK(rx_valid, 1'b0)
        // Read: one supplied byte, one idle byte, then abort while driving
        rd_mode = 1'b1; wb = xs(); tx_data = wb; tx_valid = 1'b1;
        host.tw_open(1'b1);
        host.tw_bits(8, 1'b1, 8'h00, rb);
        `CHK(rb, wb)
        host.tw_bits(8, 1'b1, 8'h00, rb);
        `CHK(rb, IDLE_BYTE)
        host.tw_lowhalf();
        `CHK(dq_oe_n, 1'b0)
        host.tw_close();
        step(4);
        `CHK({dq_oe_n, grant_tw}, 2'h2)
        // Single-wire takes the grant, three-wire is shut out
        ow_reset_chk();
        host.ow_fall();
        step(5);
        `CHK(grant_ow, 1'b1)
        s = slot_n; p = pull_n; ow_send_zero = 1'b1;
        host.ow_fall();
        step(100);
        `CHK(slot_n, s + 1)
        `CHK(pull_n > p, 1'b1)
        step(600);
        ow_send_zero = 1'b0; d = drv_n; tx_valid = 1'b1;
        host.tw_open(1'b1);
        `CHK(grant_tw, 1'b0)
        host.tw_bits(8, 1'b1, 8'h00, rb);
        `CHK(drv_n, d)
        `CHK(rb, 8'h00)
        `CHK(grant_ow, 1'b1)
        host.tw_close();
        supply_ok = 1'b0;
        step(5);
        `CHK({comm_en, grant_ow}, 2'h0)
        give_verdict();
    end
endmodule : dual_port_serial_arbiter_bench
